/* File: hdl/hb_consts.svh */
// named constants of the h-bridge control and fault block
`ifndef HB_CONSTS_SVH
`define HB_CONSTS_SVH

// clock and timing in nanoseconds, timer width in bits
`define HB_CLK_NS        10
`define HB_LIM_OFF_NS    20000
`define HB_BLANK_NS      16500
`define HB_TIMER_W       12

// junction temperature thresholds, degrees C
`define HB_TJ_FOLD_C     8'hA0
`define HB_TJ_SHUT_C     8'hAF
`define HB_TJ_HYST_C     8'h0F

// current limit levels, units of 100 mA
`define HB_CURRENT_LIMIT_LEVEL_NOM      8'h41
`define HB_CURRENT_LIMIT_LEVEL_HOT      8'h19

// register offsets
`define HB_ADDR_STAT     4'h0
`define HB_ADDR_MASK     4'h1
`define HB_ADDR_STATE    4'h2
`define HB_ADDR_LEVEL    4'h3

// register widths and reset values
`define HB_DATA_W        8
`define HB_ADDR_W        4
`define HB_EV_N          4
`define HB_STAT_RST      4'h0
`define HB_MASK_RST      4'h0

`endif

/* File: hdl/hb_pkg.sv */
// types shared by the h-bridge control and fault block
package hb_pkg;

   // main control state, one-hot
   typedef enum logic [1:0] {
      HB_ST_RUN = 2'b01,
      HB_ST_OFF = 2'b10
   } hb_state_t;

   // control pins after synchronisation
   typedef struct packed {
      logic dir_a;
      logic dir_b;
      logic dis_h;
      logic dis_l_n;
      logic uv;
   } hb_in_t;

   // interrupt events, same layout as status and mask
   typedef struct packed {
      logic lim;
      logic ot;
      logic sc;
      logic uv;
   } hb_ev_t;

endpackage

/* File: hdl/hb_timer.sv */
// one-shot down counter used for off-time and blanking
`timescale 1ns/1ps
module hb_timer #(
   parameter int W = 12
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         start,
   input  wire logic [W-1:0] len,
   output logic              busy,
   output logic              done
);

   logic [W-1:0] cnt_r;

   // loads on start, runs down to zero
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (start) begin
         cnt_r <= len;
      end else if (busy) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // busy while counting, done on the last counted cycle
   assign busy = (cnt_r != '0);
   assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) & ~start;

endmodule // hb_timer

/* File: hdl/hb_bridge_ctrl.sv */
// control and protection logic of a full h-bridge driver
// Overview of operation
// - motor driven only when enabled, unfaulted; inputs choose output polarity
// - both inputs high drive both high; both low brake low
// - first input sets first output, second input sets second output
// - either disable active puts both outputs in high impedance
// - undervoltage, short or overtemperature tri-state outputs, pull fault flag low
// - undervoltage recovery resumes per inputs and releases flag by itself
// - short latch holds outputs off until a disable edge clears it
// - after thermal reset outputs return only below shutdown minus hysteresis
// - current at limit tri-states outputs for a fixed off-time
// - limit level folds back above 160 C; above 175 C thermal latch
// - blanking timer at each activation; over-limit during it is a short
// - with no latch and normal temperature outputs follow the inputs
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "hb_consts.svh"
module hb_bridge_ctrl #(
   parameter int LIM_OFF_CYC = `HB_LIM_OFF_NS / `HB_CLK_NS,
   parameter int BLANK_CYC   = `HB_BLANK_NS / `HB_CLK_NS
) (
   input  wire logic                  CLOCK,
   input  wire logic                  SYS_RST,
   input  wire logic                  DIR_INPUT_A,
   input  wire logic                  DIR_INPUT_B,
   input  wire logic                  DISABLE_ACTIVE_HIGH,
   input  wire logic                  DISABLE_ACTIVE_LOW_N,
   input  wire logic                  UNDERVOLT,
   input  wire logic [7:0]            JUNC_TEMP,
   input  wire logic [7:0]            LOAD_CURRENT,
   input  wire logic [`HB_ADDR_W-1:0] REG_ADDR,
   input  wire logic [`HB_DATA_W-1:0] REG_WDATA,
   input  wire logic                  REG_WR,
   input  wire logic                  REG_RD,
   output logic      [`HB_DATA_W-1:0] REG_RDATA,
   output logic                       IRQ,
   output logic                       BRIDGE_OUT_A,
   output logic                       BRIDGE_OUT_A_OE_N,
   output logic                       BRIDGE_OUT_B,
   output logic                       BRIDGE_OUT_B_OE_N,
   output logic                       FAULT_FLAG_N_O,
   output logic                       FAULT_FLAG_N_OE_N
);

   localparam int TW = `HB_TIMER_W;

   // refuse counts the timers cannot hold
   if (LIM_OFF_CYC < 1 || LIM_OFF_CYC >= (1 << TW) || BLANK_CYC < 1 || BLANK_CYC >= (1 << TW))
   begin : g_bad_len
      $error("timer length out of range");
   end

   hb_pkg::hb_in_t    pin_w;
   hb_pkg::hb_in_t    sync1_r;
   hb_pkg::hb_in_t    s_r;
   hb_pkg::hb_in_t    p_r;
   hb_pkg::hb_state_t st_r;
   hb_pkg::hb_state_t st_nxt;
   hb_pkg::hb_ev_t    ev_w;
   logic [7:0]        tj_r;
   logic [7:0]        cur_r;
   logic              sc_r;
   logic              ot_r;
   logic              ot_wait_r;
   logic [`HB_EV_N-1:0] stat_r;
   logic [`HB_EV_N-1:0] mask_r;
   logic [`HB_EV_N-1:0] stat_nxt;

   // collect the control pins into one word
   assign pin_w = '{dir_a: DIR_INPUT_A, dir_b: DIR_INPUT_B, dis_h: DISABLE_ACTIVE_HIGH,
                    dis_l_n: DISABLE_ACTIVE_LOW_N, uv: UNDERVOLT};

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         sync1_r <= '{dir_a: 1'b0, dir_b: 1'b0, dis_h: 1'b1, dis_l_n: 1'b0, uv: 1'b0};
         s_r     <= '{dir_a: 1'b0, dir_b: 1'b0, dis_h: 1'b1, dis_l_n: 1'b0, uv: 1'b0};
         p_r     <= '{dir_a: 1'b0, dir_b: 1'b0, dis_h: 1'b1, dis_l_n: 1'b0, uv: 1'b0};
      end else begin
         sync1_r <= pin_w;
         s_r     <= sync1_r;
         p_r     <= s_r;
      end
   end

   // sampled analog measurements
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         tj_r  <= 8'h00;
         cur_r <= 8'h00;
      end else begin
         tj_r  <= JUNC_TEMP;
         cur_r <= LOAD_CURRENT;
      end
   end

   logic       dis_w;
   logic       clr_edge_w;
   logic       temp_hot_w;
   logic       temp_cool_w;
   logic [7:0] fold_w;
   logic [7:0] level_w;
   logic       cur_over_w;
   logic       drive_now_w;
   logic       blank_busy_w;
   logic       off_done_w;
   logic       sc_set_w;
   logic       lim_hit_w;
   logic       drive_ok_w;
   logic       act_w;
   logic       flag_low_w;

   assign dis_w       = s_r.dis_h | ~s_r.dis_l_n;
   // falling active-high or rising active-low disable
   assign clr_edge_w  = (p_r.dis_h & ~s_r.dis_h) | (~p_r.dis_l_n & s_r.dis_l_n);
   assign temp_hot_w  = tj_r > `HB_TJ_SHUT_C;
   // restart only below shutdown minus hysteresis
   assign temp_cool_w = tj_r < (`HB_TJ_SHUT_C - `HB_TJ_HYST_C);

   // limit level folds back linearly between 160 and 175 C
   assign fold_w  = 8'((16'(tj_r - `HB_TJ_FOLD_C) * 16'(`HB_CURRENT_LIMIT_LEVEL_NOM - `HB_CURRENT_LIMIT_LEVEL_HOT))
                       / 16'(`HB_TJ_SHUT_C - `HB_TJ_FOLD_C));
   assign level_w = (tj_r <= `HB_TJ_FOLD_C) ? `HB_CURRENT_LIMIT_LEVEL_NOM :
                    temp_hot_w ? `HB_CURRENT_LIMIT_LEVEL_HOT : `HB_CURRENT_LIMIT_LEVEL_NOM - fold_w;
   assign cur_over_w  = cur_r >= level_w;
   assign drive_now_w = ~BRIDGE_OUT_A_OE_N;

   // over-limit inside blanking window is a hard short
   assign sc_set_w   = drive_now_w & blank_busy_w & cur_over_w;
   // over-limit after blanking starts the off-time
   assign lim_hit_w  = drive_now_w & ~blank_busy_w & cur_over_w & (st_r == hb_pkg::HB_ST_RUN);

   // drive only when enabled, unfaulted, not in off-time
   assign drive_ok_w = ~dis_w & ~s_r.uv & ~sc_r & ~ot_r & ~ot_wait_r & ~temp_hot_w
                       & (st_r == hb_pkg::HB_ST_RUN) & ~lim_hit_w & ~sc_set_w;
   assign act_w      = drive_ok_w & ~drive_now_w;

   // flag low on any fault, and while disabled
   assign flag_low_w = dis_w | s_r.uv | sc_r | ot_r;

   // fault latches; a new fault wins over a clearing edge
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         sc_r      <= 1'b0;
         ot_r      <= 1'b0;
         ot_wait_r <= 1'b0;
      end else begin
         // short latch held until a disable edge
         sc_r      <= sc_set_w | (sc_r & ~clr_edge_w);
         ot_r      <= temp_hot_w | (ot_r & ~clr_edge_w);
         // cleared latch waits for the hysteresis point
         ot_wait_r <= ((ot_r & clr_edge_w) | ot_wait_r) & ~temp_cool_w;
      end
   end

   // fixed off-time after the limit is reached
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         hb_pkg::HB_ST_RUN: begin
            if (lim_hit_w) begin
               st_nxt = hb_pkg::HB_ST_OFF;
            end
         end
         hb_pkg::HB_ST_OFF: begin
            if (off_done_w) begin
               st_nxt = hb_pkg::HB_ST_RUN;
            end
         end
         default: st_nxt = hb_pkg::HB_ST_RUN;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         st_r <= hb_pkg::HB_ST_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // off-time timer
   hb_timer #(.W(TW)) u_off_timer (
      .clk   (CLOCK),
      .rst   (SYS_RST),
      .start (lim_hit_w),
      .len   (TW'(LIM_OFF_CYC)),
      .busy  (),
      .done  (off_done_w)
   );

   // blanking timer restarted at every activation
   hb_timer #(.W(TW)) u_blank_timer (
      .clk   (CLOCK),
      .rst   (SYS_RST),
      .start (act_w),
      .len   (TW'(BLANK_CYC)),
      .busy  (blank_busy_w),
      .done  ()
   );

   // each half-bridge follows its own input
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         BRIDGE_OUT_A      <= 1'b0;
         BRIDGE_OUT_B      <= 1'b0;
         BRIDGE_OUT_A_OE_N <= 1'b1;
         BRIDGE_OUT_B_OE_N <= 1'b1;
         FAULT_FLAG_N_O    <= 1'b0;
         FAULT_FLAG_N_OE_N <= 1'b1;
      end else begin
         BRIDGE_OUT_A      <= drive_ok_w & s_r.dir_a;
         BRIDGE_OUT_B      <= drive_ok_w & s_r.dir_b;
         BRIDGE_OUT_A_OE_N <= ~drive_ok_w;
         BRIDGE_OUT_B_OE_N <= ~drive_ok_w;
         FAULT_FLAG_N_O    <= 1'b0;
         FAULT_FLAG_N_OE_N <= ~flag_low_w;
      end
   end

   // register decode and interrupt events
   logic                  wr_stat_w;
   logic                  wr_mask_w;
   logic [`HB_DATA_W-1:0] rd_mux_w;

   assign wr_stat_w = REG_WR & (REG_ADDR == `HB_ADDR_STAT);
   assign wr_mask_w = REG_WR & (REG_ADDR == `HB_ADDR_MASK);
   assign ev_w      = '{lim: lim_hit_w, ot: temp_hot_w & ~ot_r,
                        sc: sc_set_w & ~sc_r, uv: s_r.uv & ~p_r.uv};
   // set wins over a write-one clear
   assign stat_nxt  = (stat_r & ~(wr_stat_w ? REG_WDATA[`HB_EV_N-1:0] : `HB_STAT_RST))
                      | ev_w;
   assign rd_mux_w  = (REG_ADDR == `HB_ADDR_STAT)  ? {4'h0, stat_r} :
                      (REG_ADDR == `HB_ADDR_MASK)  ? {4'h0, mask_r} :
                      (REG_ADDR == `HB_ADDR_STATE) ? {ot_wait_r, ot_r, sc_r, s_r.uv,
                                                      dis_w, st_r[1], drive_now_w,
                                                      flag_low_w} :
                      (REG_ADDR == `HB_ADDR_LEVEL) ? level_w : 8'h00;

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         stat_r    <= `HB_STAT_RST;
         mask_r    <= `HB_MASK_RST;
         REG_RDATA <= 8'h00;
         IRQ       <= 1'b0;
      end else begin
         stat_r    <= stat_nxt;
         mask_r    <= wr_mask_w ? REG_WDATA[`HB_EV_N-1:0] : mask_r;
         REG_RDATA <= REG_RD ? rd_mux_w : 8'h00;
         IRQ       <= |(stat_r & mask_r);
      end
   end

   // helper: cycles spent in off-time
   logic [TW-1:0] off_cnt_r;
   always_ff @(posedge CLOCK) begin
      if (SYS_RST || st_r != hb_pkg::HB_ST_OFF) begin
         off_cnt_r <= '0;
      end else begin
         off_cnt_r <= off_cnt_r + 1'b1;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   sequence s_edge_clear;
      clr_edge_w && !sc_set_w;
   endsequence

   chk_disable_tristate: assert property (
      dis_w |=> BRIDGE_OUT_A_OE_N && BRIDGE_OUT_B_OE_N)
      else $error("outputs driven while disabled");

   chk_fault_flag_low: assert property (
      (s_r.uv || sc_r || ot_r) |=> !FAULT_FLAG_N_OE_N && BRIDGE_OUT_A_OE_N)
      else $error("fault without flag or tri-state");

   chk_uv_resume: assert property (
      $fell(s_r.uv) && !dis_w && !sc_r && !ot_r |=> FAULT_FLAG_N_OE_N)
      else $error("flag not released after undervoltage");

   chk_short_hold: assert property (
      sc_r && !clr_edge_w |=> sc_r)
      else $error("short latch dropped without edge");

   chk_short_clear: assert property (
      sc_r ##0 s_edge_clear |=> !sc_r)
      else $error("short latch not cleared by edge");

   chk_follow_inputs: assert property (
      drive_ok_w |=> !BRIDGE_OUT_A_OE_N && BRIDGE_OUT_A == $past(s_r.dir_a)
                     && BRIDGE_OUT_B == $past(s_r.dir_b))
      else $error("outputs do not follow inputs");

   chk_brake_low: assert property (
      drive_ok_w && !s_r.dir_a && !s_r.dir_b |=> !BRIDGE_OUT_A && !BRIDGE_OUT_B
                                                  && !BRIDGE_OUT_B_OE_N)
      else $error("brake low not applied");

   chk_offtime_len: assert property (
      st_r == hb_pkg::HB_ST_OFF && st_nxt == hb_pkg::HB_ST_RUN
      |-> off_cnt_r == TW'(LIM_OFF_CYC - 1))
      else $error("off-time length wrong");

   chk_blank_short: assert property (
      sc_set_w |=> sc_r && BRIDGE_OUT_A_OE_N [*2])
      else $error("short in blanking not latched");

   chk_thermal_latch: assert property (
      tj_r > `HB_TJ_SHUT_C |=> ot_r ##1 BRIDGE_OUT_A_OE_N)
      else $error("overtemperature not latched");

   chk_thermal_wait: assert property (
      ot_wait_r && !temp_cool_w |=> BRIDGE_OUT_A_OE_N)
      else $error("restart before hysteresis point");

endmodule // hb_bridge_ctrl

/* File: test/hb_host_model.sv */
// host controller model driving the bridge control pins
`timescale 1ns/1ps
module hb_host_model (
   input  wire logic clk,
   input  wire logic flag_o,
   input  wire logic flag_oe_n,
   output logic      dir_a,
   output logic      dir_b,
   output logic      dis_h,
   output logic      dis_l_n,
   output logic      flag_level
);
   // pull-up on the open-drain fault line
   assign flag_level = flag_oe_n ? 1'b1 : flag_o;

   // pins start enabled with both directions low
   initial begin
      dir_a = 1'b0;
      dir_b = 1'b0;
      dis_h = 1'b0;
      dis_l_n = 1'b1;
   end

   // direction changes kept apart, scaled stand-in for the pwm ceiling
   localparam int MIN_DIR_GAP = 6;
   int cyc_cnt = 0;
   int last_dir_cyc = 0;
   always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

   // pins move just after an edge, direction toggles kept slow
   task automatic set_pins(input logic a, input logic b, input logic h, input logic l_n);
      @(posedge clk);
      while ((a !== dir_a || b !== dir_b) && (cyc_cnt - last_dir_cyc) < MIN_DIR_GAP) begin
         @(posedge clk);
      end
      if (a !== dir_a || b !== dir_b) begin
         last_dir_cyc = cyc_cnt;
      end
      dir_a <= a;
      dir_b <= b;
      dis_h <= h;
      dis_l_n <= l_n;
   endtask
endmodule // hb_host_model

/* File: test/test_hbridge_control_fault_logic.sv */
// self-checking bench of the h-bridge control and fault block
`timescale 1ns/1ps
`include "hb_consts.svh"
module test_hbridge_control_fault_logic;
   logic       clock;
   logic       sys_rst;
   logic       uv;
   logic [7:0] temp;
   logic [7:0] cur;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic       we;
   logic       re;
   logic [7:0] rdata;
   logic       irq;
   logic       out_a;
   logic       oe_a_n;
   logic       out_b;
   logic       oe_b_n;
   logic       flag_o;
   logic       flag_oe_n;
   logic       dir_a;
   logic       dir_b;
   logic       dis_h;
   logic       dis_l_n;
   logic       flag_level;
   int         num_errors = 0;
   int         total_checks = 0;
   logic [7:0] rv;

   // clock and static inputs
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      sys_rst = 1'b1;
      uv = 1'b0;
      temp = 8'h19;
      cur = 8'h00;
      addr = 4'h0;
      wdata = 8'h00;
      we = 1'b0;
      re = 1'b0;
   end

   hb_bridge_ctrl #(.LIM_OFF_CYC(20), .BLANK_CYC(15)) DUT (
      .CLOCK(clock), .SYS_RST(sys_rst), .DIR_INPUT_A(dir_a), .DIR_INPUT_B(dir_b),
      .DISABLE_ACTIVE_HIGH(dis_h), .DISABLE_ACTIVE_LOW_N(dis_l_n), .UNDERVOLT(uv),
      .JUNC_TEMP(temp), .LOAD_CURRENT(cur), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .IRQ(irq),
      .BRIDGE_OUT_A(out_a), .BRIDGE_OUT_A_OE_N(oe_a_n), .BRIDGE_OUT_B(out_b),
      .BRIDGE_OUT_B_OE_N(oe_b_n), .FAULT_FLAG_N_O(flag_o), .FAULT_FLAG_N_OE_N(flag_oe_n));

   hb_host_model u_host (
      .clk(clock), .flag_o(flag_o), .flag_oe_n(flag_oe_n), .dir_a(dir_a), .dir_b(dir_b),
      .dis_h(dis_h), .dis_l_n(dis_l_n), .flag_level(flag_level));

   // compare tasks and closing
   task automatic chk1(input string n, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // bus cycles and waits
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clock);
      we <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      re <= 1'b1;
      @(posedge clock);
      re <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic expect_out(input logic oe, input logic a, input logic b, input logic fl);
      chk1("oe_a_n", oe, oe_a_n);
      chk1("oe_b_n", oe, oe_b_n);
      chk1("out_a", a, out_a);
      chk1("out_b", b, out_b);
      chk1("flag", fl, flag_level);
   endtask
   task automatic wait_drive;
      for (int i = 0; i < 10 && oe_b_n !== 1'b0; i++) @(negedge clock);
   endtask
   task automatic toggle_clear(input logic a, input logic b);
      u_host.set_pins(a, b, 1'b1, 1'b1);
      cyc(6);
      u_host.set_pins(a, b, 1'b0, 1'b1);
      cyc(6);
   endtask

   // reset values and unmapped address
   task automatic t_regs;
      reg_rd(`HB_ADDR_STAT, rv);
      chk8("status", 8'h00, rv);
      reg_rd(`HB_ADDR_MASK, rv);
      chk8("mask", 8'h00, rv);
      reg_wr(4'h7, 8'hFF);
      reg_rd(4'h7, rv);
      chk8("unmapped", 8'h00, rv);
   endtask

   // every direction pair while enabled
   task automatic t_truth;
      for (int i = 0; i < 4; i++) begin
         u_host.set_pins(i[1], i[0], 1'b0, 1'b1);
         cyc(6);
         expect_out(1'b0, i[1], i[0], 1'b1);
      end
   endtask

   // each disable pin alone
   task automatic t_disable;
      u_host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
      cyc(6);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      u_host.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
      cyc(6);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      u_host.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
      cyc(6);
      expect_out(1'b0, 1'b1, 1'b0, 1'b1);
   endtask

   // undervoltage, auto recovery, interrupt mask and clear
   task automatic t_uv_irq;
      @(posedge clock) uv <= 1'b1;
      cyc(6);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      reg_rd(`HB_ADDR_STAT, rv);
      chk8("status", 8'h01, rv);
      chk1("irq", 1'b0, irq);
      reg_wr(`HB_ADDR_MASK, 8'h01);
      cyc(2);
      chk1("irq", 1'b1, irq);
      @(posedge clock) uv <= 1'b0;
      cyc(6);
      expect_out(1'b0, 1'b1, 1'b0, 1'b1);
      chk1("irq", 1'b1, irq);
      reg_wr(`HB_ADDR_STAT, 8'h01);
      cyc(2);
      chk1("irq", 1'b0, irq);
      reg_wr(`HB_ADDR_MASK, 8'h00);
   endtask

   // over-limit inside blanking latches until a disable edge
   task automatic t_short;
      u_host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
      cyc(6);
      u_host.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
      wait_drive;
      @(posedge clock) cur <= 8'h41;
      @(posedge clock) cur <= 8'h00;
      cyc(4);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      reg_rd(`HB_ADDR_STATE, rv);
      chk1("sc_latch", 1'b1, rv[5]);
      u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
      cyc(8);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      toggle_clear(1'b0, 1'b1);
      expect_out(1'b0, 1'b0, 1'b1, 1'b1);
   endtask

   // limit hit after blanking gives the fixed off-time
   task automatic t_limit;
      int n;
      n = 0;
      cyc(30);
      @(posedge clock) cur <= 8'h41;
      @(posedge clock) cur <= 8'h00;
      for (int i = 0; i < 10 && oe_b_n !== 1'b1; i++) @(negedge clock);
      while (oe_b_n === 1'b1 && n < 100) begin
         n++;
         @(negedge clock);
      end
      // off-time of 20 cycles plus one for the registered outputs
      chk8("off_cycles", 8'h15, 8'(n));
      expect_out(1'b0, 1'b0, 1'b1, 1'b1);
      reg_rd(`HB_ADDR_STAT, rv);
      chk1("lim_event", 1'b1, rv[3]);
      chk1("sc_event", 1'b1, rv[1]);
   endtask

   // fold-back ends, thermal latch, restart only when cool
   task automatic t_thermal;
      @(posedge clock) temp <= 8'hA0;
      cyc(3);
      reg_rd(`HB_ADDR_LEVEL, rv);
      chk8("level_160", 8'h41, rv);
      @(posedge clock) temp <= 8'hAF;
      cyc(3);
      reg_rd(`HB_ADDR_LEVEL, rv);
      chk8("level_175", 8'h19, rv);
      @(posedge clock) temp <= 8'hB0;
      cyc(6);
      expect_out(1'b1, 1'b0, 1'b0, 1'b0);
      reg_rd(`HB_ADDR_STATE, rv);
      chk1("ot_latch", 1'b1, rv[6]);
      @(posedge clock) temp <= 8'hAA;
      toggle_clear(1'b0, 1'b1);
      expect_out(1'b1, 1'b0, 1'b0, 1'b1);
      @(posedge clock) temp <= 8'h96;
      cyc(6);
      expect_out(1'b0, 1'b0, 1'b1, 1'b1);
      reg_rd(`HB_ADDR_STAT, rv);
      chk1("ot_event", 1'b1, rv[2]);
   endtask

   // main sequence
   initial begin
      cyc(4);
      sys_rst <= 1'b0;
      t_regs;
      cyc(6);
      t_truth;
      t_disable;
      t_uv_irq;
      t_short;
      t_limit;
      t_thermal;
      tally_and_finish;
   end

   // watchdog against a hang
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
endmodule // test_hbridge_control_fault_logic
